// File: design/tdp_prog.sv
/*
 * Programming side of the exerciser target: decoder and attribute
 * staging, eight decoders, pointer and paged attribute memory, fed by
 * a valid/ready command port with one answer pulse per command.
 * Assumes one clock, synchronous reset and a bus_busy level input.
 */
`timescale 1ns/1ps

module tdp_prog import tdp_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input tdp_cmd_t cmd,
  output logic cmd_ready,
  // Answer
  output logic rsp_valid,
  output logic [3:0] rsp_err,
  output logic [31:0] rsp_data,
  // Target state machine side
  input wire logic bus_busy,
  input wire logic [PTR_W-1:0] tgt_line_idx,
  output tdp_attr_t tgt_line,
  output logic [7:0] tgt_page,
  output logic [NUM_DEC-1:0] dec_active,
  output tdp_dec_cfg_t [NUM_DEC-1:0] dec_cfg
);

  // ==========================================================
  // State
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_INIT = 1'b1} tdp_state_t;

  tdp_state_t state_q;
  logic [4:0] init_cnt_q;
  logic [7:0] init_page_q;
  tdp_dec_cfg_t dec_stage_q;
  tdp_dec_cfg_t dec_q [NUM_DEC];
  tdp_attr_t attr_stage_q;
  logic [PTR_W-1:0] ptr_q;
  logic [7:0] page_sel_q;
  logic page0_rd_q;
  logic take;
  logic [2:0] dec_idx;
  logic dec_num_ok;
  tdp_dec_cfg_t commit_cfg;
  logic commit_ok;
  logic [PTR_W:0] place_sum;
  logic [3:0] err;
  logic mem_we;
  logic [PTR_W-1:0] mem_waddr;
  tdp_attr_t mem_wdata;
  logic [PTR_W-1:0] mem_raddr;
  tdp_attr_t mem_rdata;
  assign cmd_ready = (state_q == ST_IDLE);
  assign take = cmd_valid && cmd_ready;
  assign dec_idx = 3'(cmd.dec_num - 4'h1);
  assign dec_num_ok = (cmd.dec_num >= 4'h1) &&
                      (cmd.dec_num <= 4'(NUM_DEC));
  assign commit_cfg = (cmd.op == OP_DEC_SET_AND_COMMIT) ?
                      cmd.dec_cfg : dec_stage_q;
  assign place_sum = {1'b0, cmd.page, 5'h00} + {1'b0, cmd.offset};
  tdp_dec_check u_check (
    .dec_num(cmd.dec_num),
    .cfg(commit_cfg),
    .ok(commit_ok)
  );

  // ==========================================================
  // Command verdict
  always_comb begin
    err = ERR_NONE;
    case (cmd.op)
      OP_DEC_STAGE_WRITE: err = (cmd.prop > DP_PREFETCH) ? ERR_PROP : ERR_NONE;
      OP_DEC_COMMIT, OP_DEC_SET_AND_COMMIT: begin
        if (bus_busy) begin
          err = ERR_BUSY;
        end else if (!dec_num_ok) begin
          err = ERR_DEC_NUM;
        end else if (!commit_ok) begin
          err = ERR_INCONSISTENT;
        end
      end
      OP_DEC_READBACK: begin
        if (bus_busy) begin
          err = ERR_BUSY;
        end else if (!dec_num_ok) begin
          err = ERR_DEC_NUM;
        end
      end
      OP_DEC_STAGED_QUERY: begin
        if (bus_busy) begin
          err = ERR_BUSY;
        end else if (cmd.prop > DP_PREFETCH) begin
          err = ERR_PROP;
        end
      end
      OP_ATTR_PAGE_INIT:
        err = (cmd.page < PAGE_FIRST_USER) ? ERR_PAGE : ERR_NONE;
      OP_ATTR_POINTER_PLACE: begin
        if (cmd.page < PAGE_FIRST_USER) begin
          err = ERR_PAGE;
        end else if (place_sum[PTR_W]) begin
          err = ERR_RANGE;
        end
      end
      OP_ATTR_STAGE_WRITE: begin
        if (cmd.prop > AP_WRPAR) begin
          err = ERR_PROP;
        end else if ((cmd.prop == AP_WAITS && cmd.value > 32'h1F) ||
                     (cmd.prop == AP_TERM && cmd.value > 32'h3) ||
                     (cmd.prop != AP_WAITS && cmd.prop != AP_TERM &&
                      cmd.value > 32'h1)) begin
          err = ERR_RANGE;
        end
      end
      // A pointer that wrapped into page zero may not write it.
      OP_ATTR_LINE_WRITE:
        err = (ptr_q < PTR_W'(PAGE_LINES)) ? ERR_PAGE : ERR_NONE;
      OP_ATTR_STAGE_DEFAULTS, OP_ATTR_PAGE_SELECT: err = ERR_NONE;
      OP_ATTR_STAGE_QUERY: err = (cmd.prop > AP_WRPAR) ? ERR_PROP : ERR_NONE;
      default: err = ERR_OP;
    endcase
  end

  // ==========================================================
  // Page initialise sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      init_cnt_q <= 5'h00;
      init_page_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && cmd.op == OP_ATTR_PAGE_INIT && err == ERR_NONE) begin
            state_q <= ST_INIT;
            init_cnt_q <= 5'h00;
            init_page_q <= cmd.page;
          end
        end
        ST_INIT: begin
          init_cnt_q <= init_cnt_q + 5'h01;
          if (init_cnt_q == LAST_LINE) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Decoder staging and committed decoders
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dec_stage_q <= DEC_RESET;
      for (int i = 0; i < NUM_DEC; i++) begin
        dec_q[i] <= DEC_RESET;
      end
    end else if (take && err == ERR_NONE) begin
      case (cmd.op)
        OP_DEC_STAGE_WRITE: begin
          case (cmd.prop)
            DP_MODE: dec_stage_q.mode <= cmd.value[0];
            DP_SIZE: dec_stage_q.size <= cmd.value[4:0];
            DP_BASE: dec_stage_q.base <= cmd.value;
            DP_SPEED: dec_stage_q.speed <= cmd.value[0];
            DP_LOCATION: dec_stage_q.location <= cmd.value[2:0];
            default: dec_stage_q.prefetch <= cmd.value[0];
          endcase
        end
        OP_DEC_COMMIT: dec_q[dec_idx] <= dec_stage_q;
        OP_DEC_SET_AND_COMMIT: begin
          dec_stage_q <= cmd.dec_cfg;
          dec_q[dec_idx] <= cmd.dec_cfg;
        end
        OP_DEC_READBACK: dec_stage_q <= dec_q[dec_idx];
        default: dec_stage_q <= dec_stage_q;
      endcase
    end
  end
  genvar g;
  generate
    for (g = 0; g < NUM_DEC; g++) begin : g_dec
      assign dec_cfg[g] = dec_q[g];
      assign dec_active[g] = (dec_q[g].size != 5'h00);
    end
  endgenerate

  // ==========================================================
  // Attribute staging, pointer and selected page
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      attr_stage_q <= ATTR_DEFAULT;
    end else if (take && err == ERR_NONE) begin
      if (cmd.op == OP_ATTR_STAGE_DEFAULTS) begin
        attr_stage_q <= ATTR_DEFAULT;
      end else if (cmd.op == OP_ATTR_STAGE_WRITE) begin
        // Only staging changes here; the target never reads it.
        case (cmd.prop)
          AP_LOOP: attr_stage_q.loop <= cmd.value[0];
          AP_WAITS: attr_stage_q.waits <= cmd.value[4:0];
          AP_TERM: attr_stage_q.term <= cmd.value[1:0];
          AP_DPERR: attr_stage_q.dperr <= cmd.value[0];
          AP_DSERR: attr_stage_q.dserr <= cmd.value[0];
          AP_APERR: attr_stage_q.aperr <= cmd.value[0];
          default: attr_stage_q.wrpar <= cmd.value[0];
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ptr_q <= PTR_W'(PAGE_LINES);
    end else if (take && err == ERR_NONE) begin
      case (cmd.op)
        OP_ATTR_PAGE_INIT: ptr_q <= {cmd.page, 5'h00};
        OP_ATTR_POINTER_PLACE: ptr_q <= place_sum[PTR_W-1:0];
        OP_ATTR_LINE_WRITE: ptr_q <= ptr_q + PTR_W'(1);
        OP_DEC_COMMIT, OP_DEC_SET_AND_COMMIT:
          ptr_q <= {ptr_q[PTR_W-1:5], 5'h00};
        default: ptr_q <= ptr_q;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      page_sel_q <= 8'h00;
    end else if (take && cmd.op == OP_ATTR_PAGE_SELECT) begin
      page_sel_q <= cmd.page;
    end
  end
  assign tgt_page = page_sel_q;

  // ==========================================================
  // Attribute memory
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = ptr_q;
    mem_wdata = attr_stage_q;
    if (state_q == ST_INIT) begin
      mem_we = 1'b1;
      mem_waddr = {init_page_q, init_cnt_q};
      mem_wdata = ATTR_INIT_LINE;
    end else if (take && cmd.op == OP_ATTR_LINE_WRITE &&
                 err == ERR_NONE) begin
      mem_we = 1'b1;
    end
  end

  // Lines past the page end fall into the next page.
  assign mem_raddr = {page_sel_q, 5'h00} + tgt_line_idx;
  tdp_attr_mem u_mem (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );
  // Page zero is not stored; it always answers the fixed line ATTR_INIT_LINE (loop set).
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      page0_rd_q <= 1'b1;
    end else begin
      page0_rd_q <= (mem_raddr < PTR_W'(PAGE_LINES));
    end
  end
  assign tgt_line = page0_rd_q ? ATTR_INIT_LINE : mem_rdata;

  // ==========================================================
  // Answers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_err <= ERR_NONE;
      rsp_data <= 32'h00000000;
    end else begin
      rsp_valid <= 1'b0;
      if (state_q == ST_INIT && init_cnt_q == LAST_LINE) begin
        rsp_valid <= 1'b1;
        rsp_err <= ERR_NONE;
        rsp_data <= 32'h00000000;
      end else if (take &&
                   !(cmd.op == OP_ATTR_PAGE_INIT && err == ERR_NONE)) begin
        rsp_valid <= 1'b1;
        rsp_err <= err;
        rsp_data <= 32'h00000000;
        if (err == ERR_NONE && cmd.op == OP_DEC_STAGED_QUERY) begin
          case (cmd.prop)
            DP_MODE: rsp_data <= 32'(dec_stage_q.mode);
            DP_SIZE: rsp_data <= 32'(dec_stage_q.size);
            DP_BASE: rsp_data <= dec_stage_q.base;
            DP_SPEED: rsp_data <= 32'(dec_stage_q.speed);
            DP_LOCATION: rsp_data <= 32'(dec_stage_q.location);
            default: rsp_data <= 32'(dec_stage_q.prefetch);
          endcase
        end else if (err == ERR_NONE && cmd.op == OP_ATTR_STAGE_QUERY) begin
          case (cmd.prop)
            AP_LOOP: rsp_data <= 32'(attr_stage_q.loop);
            AP_WAITS: rsp_data <= 32'(attr_stage_q.waits);
            AP_TERM: rsp_data <= 32'(attr_stage_q.term);
            AP_DPERR: rsp_data <= 32'(attr_stage_q.dperr);
            AP_DSERR: rsp_data <= 32'(attr_stage_q.dserr);
            AP_APERR: rsp_data <= 32'(attr_stage_q.aperr);
            default: rsp_data <= 32'(attr_stage_q.wrpar);
          endcase
        end
      end
    end
  end

endmodule // tdp_prog

// File: design/tdp_pkg.sv
/*
 * Shared constants and types of the target decoder and attribute
 * programming block. Assumes a single synchronous clock domain.
 */
package tdp_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NUM_DEC = 8;
  localparam int unsigned NUM_PAGES = 256;
  localparam int unsigned PAGE_LINES = 32;
  localparam int unsigned MEM_LINES = NUM_PAGES * PAGE_LINES;
  localparam int unsigned PTR_W = 13;
  localparam logic [7:0] PAGE_FIRST_USER = 8'h01;
  localparam logic [4:0] LAST_LINE = 5'h1F;

  // ==========================================================
  // Commands
  typedef enum logic [3:0] {
    OP_DEC_STAGE_WRITE     = 4'h0,
    OP_DEC_COMMIT          = 4'h1,
    OP_DEC_SET_AND_COMMIT  = 4'h2,
    OP_DEC_READBACK        = 4'h3,
    OP_DEC_STAGED_QUERY    = 4'h4,
    OP_ATTR_PAGE_INIT      = 4'h5,
    OP_ATTR_POINTER_PLACE  = 4'h6,
    OP_ATTR_STAGE_DEFAULTS = 4'h7,
    OP_ATTR_STAGE_WRITE    = 4'h8,
    OP_ATTR_LINE_WRITE     = 4'h9,
    OP_ATTR_PAGE_SELECT    = 4'hA,
    OP_ATTR_STAGE_QUERY    = 4'hB
  } tdp_op_t;

  // Decoder property selectors.
  localparam logic [3:0] DP_MODE = 4'h0;
  localparam logic [3:0] DP_SIZE = 4'h1;
  localparam logic [3:0] DP_BASE = 4'h2;
  localparam logic [3:0] DP_SPEED = 4'h3;
  localparam logic [3:0] DP_LOCATION = 4'h4;
  localparam logic [3:0] DP_PREFETCH = 4'h5;

  // Attribute property selectors.
  localparam logic [3:0] AP_LOOP = 4'h0;
  localparam logic [3:0] AP_WAITS = 4'h1;
  localparam logic [3:0] AP_TERM = 4'h2;
  localparam logic [3:0] AP_DPERR = 4'h3;
  localparam logic [3:0] AP_DSERR = 4'h4;
  localparam logic [3:0] AP_APERR = 4'h5;
  localparam logic [3:0] AP_WRPAR = 4'h6;

  // Status codes returned with every answer.
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_BUSY = 4'h1;
  localparam logic [3:0] ERR_DEC_NUM = 4'h2;
  localparam logic [3:0] ERR_INCONSISTENT = 4'h3;
  localparam logic [3:0] ERR_PAGE = 4'h4;
  localparam logic [3:0] ERR_RANGE = 4'h5;
  localparam logic [3:0] ERR_PROP = 4'h6;
  localparam logic [3:0] ERR_OP = 4'h7;

  // ==========================================================
  // Decoder settings and mode encodings
  localparam logic MODE_MEM = 1'b0;
  localparam logic MODE_IO = 1'b1;

  typedef struct packed {
    logic mode;
    logic [4:0] size;
    logic [31:0] base;
    logic speed;
    logic [2:0] location;
    logic prefetch;
  } tdp_dec_cfg_t;

  localparam tdp_dec_cfg_t DEC_RESET = '0;

  // ==========================================================
  // One attribute line
  typedef struct packed {
    logic loop;
    logic [4:0] waits;
    logic [1:0] term;
    logic dperr;
    logic dserr;
    logic aperr;
    logic wrpar;
  } tdp_attr_t;

  localparam tdp_attr_t ATTR_DEFAULT = '0;
  localparam tdp_attr_t ATTR_INIT_LINE = '{loop: 1'b1, default: '0};

  // ==========================================================
  // Command bundle
  typedef struct packed {
    tdp_op_t op;
    logic [3:0] dec_num;
    logic [7:0] page;
    logic [PTR_W-1:0] offset;
    logic [3:0] prop;
    logic [31:0] value;
    tdp_dec_cfg_t dec_cfg;
  } tdp_cmd_t;

endpackage

// File: design/tdp_dec_check.sv
/*
 * Consistency check of staged decoder settings against the decoder
 * number they are committed to. Purely combinational.
 */
`timescale 1ns/1ps
module tdp_dec_check import tdp_pkg::*; (
  // Staged settings and target decoder
  input wire logic [3:0] dec_num,
  input tdp_dec_cfg_t cfg,
  // Verdict
  output logic ok
);

  logic [31:0] gran_mask;
  logic size_ok;
  logic mode_ok;

  // On decoders 1 to 3 and 7 the base must be aligned to the programmed power-of-two size.
  assign gran_mask = ~(32'hFFFFFFFF << cfg.size);

  always_comb begin
    size_ok = 1'b0;
    mode_ok = 1'b1;
    case (dec_num)
      4'h1: begin
        mode_ok = (cfg.mode == MODE_MEM);
        size_ok = (cfg.size == 5'h00) ||
                  (cfg.size >= 5'h0C && cfg.size <= 5'h18);
      end
      4'h2: begin
        size_ok = (cfg.size == 5'h00) ||
                  (cfg.size >= 5'h04 && cfg.size <= 5'h10);
      end
      4'h3: begin
        mode_ok = (cfg.mode == MODE_IO);
        size_ok = (cfg.size == 5'h00) ||
                  (cfg.size >= 5'h06 && cfg.size <= 5'h10);
      end
      4'h4, 4'h5, 4'h6: begin
        size_ok = (cfg.size <= 5'h01);
      end
      4'h7: begin
        size_ok = (cfg.size == 5'h00) || (cfg.size == 5'h05);
      end
      4'h8: begin
        size_ok = (cfg.size == 5'h00) || (cfg.size == 5'h12);
      end
      default: begin
        size_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    ok = size_ok && mode_ok;
    // Decode speed can only be raised on the first two decoders.
    if (cfg.speed && dec_num != 4'h1 && dec_num != 4'h2) begin
      ok = 1'b0;
    end
    if ((dec_num <= 4'h3 || dec_num == 4'h7) &&
        (cfg.base & gran_mask) != 32'h00000000) begin
      ok = 1'b0;
    end
  end

endmodule // tdp_dec_check

// File: design/tdp_attr_mem.sv
/*
 * Attribute line memory: one write port, one registered read port.
 * Contents are not cleared by reset; lines hold until rewritten.
 */
`timescale 1ns/1ps
module tdp_attr_mem import tdp_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Write port
  input wire logic wr_en,
  input wire logic [PTR_W-1:0] wr_addr,
  input tdp_attr_t wr_data,
  // Read port
  input wire logic [PTR_W-1:0] rd_addr,
  output tdp_attr_t rd_data
);

  tdp_attr_t mem_q [MEM_LINES];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= mem_q[rd_addr];
  end

endmodule // tdp_attr_mem

// File: tb/tdp_prog_properties.sv
/*
 * Concurrent checks on the ports of the programming block.
 * Assumes tdp_pkg is compiled first and the bind below finds tdp_prog.
 */
`timescale 1ns/1ps
module tdp_prog_properties import tdp_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Command and answer
  input wire logic cmd_valid,
  input tdp_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [3:0] rsp_err,
  input wire logic [31:0] rsp_data,
  // Target side
  input wire logic bus_busy,
  input wire logic [PTR_W-1:0] tgt_line_idx,
  input tdp_attr_t tgt_line,
  input wire logic [7:0] tgt_page,
  input wire logic [NUM_DEC-1:0] dec_active,
  input tdp_dec_cfg_t [NUM_DEC-1:0] dec_cfg
);
  // ==========================================================
  // Helpers
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic take;
  logic dec_op;
  logic init_ok;
  logic [NUM_DEC-1:0] size_nz;
  assign take = cmd_valid && cmd_ready;
  assign dec_op = cmd.op inside {OP_DEC_COMMIT, OP_DEC_SET_AND_COMMIT,
    OP_DEC_READBACK, OP_DEC_STAGED_QUERY};
  assign init_ok = take && cmd.op == OP_ATTR_PAGE_INIT && cmd.page != 8'h00;
  always_comb begin
    for (int i = 0; i < NUM_DEC; i++) begin
      size_nz[i] = dec_cfg[i].size != 5'h00;
    end
  end

  // ==========================================================
  // Properties
  AST_BUSY_REFUSE: assert property (take && bus_busy && dec_op |=>
    rsp_valid && rsp_err == ERR_BUSY && $stable(dec_cfg))
    else $error("busy decoder command not refused");
  AST_DEC_NUMBER: assert property (take && !bus_busy &&
    cmd.op == OP_DEC_COMMIT && (cmd.dec_num == 4'h0 || cmd.dec_num > 4'h8)
    |=> rsp_valid && rsp_err == ERR_DEC_NUM)
    else $error("bad decoder number accepted");
  AST_ACTIVE_SIZE: assert property (dec_active == size_nz)
    else $error("decoder active flag does not follow size");
  AST_INIT_HOLD: assert property (init_ok |=> !cmd_ready [*8])
    else $error("ready during page fill");
  AST_INIT_DONE: assert property (init_ok |->
    ##33 rsp_valid && rsp_err == ERR_NONE)
    else $error("page fill answer not at 33 cycles");
  AST_PAGE_ZERO: assert property (take && cmd.page == 8'h00 &&
    cmd.op inside {OP_ATTR_PAGE_INIT, OP_ATTR_POINTER_PLACE}
    |=> rsp_valid && rsp_err == ERR_PAGE)
    else $error("page zero accepted");
  AST_PAGE_SELECT: assert property (take &&
    cmd.op == OP_ATTR_PAGE_SELECT |=> tgt_page == $past(cmd.page))
    else $error("selected page not applied");
  AST_STAGE_QUIET: assert property (take && cmd.op inside
    {OP_ATTR_STAGE_WRITE, OP_ATTR_STAGE_DEFAULTS}
    |=> $stable(dec_active) && $stable(tgt_page))
    else $error("staging write changed target state");
  AST_ONE_ANSWER: assert property (take &&
    cmd.op != OP_ATTR_PAGE_INIT |=> rsp_valid)
    else $error("answer missing one cycle after take");
  AST_PAGE0_LINE: assert property (!$past(sys_rst, 2) &&
    $past(tgt_page, 2) == 8'h00 && $past(tgt_page) == 8'h00 &&
    $past(tgt_line_idx) < 13'h0020
    |-> tgt_line == ATTR_INIT_LINE)
    else $error("page zero line not default with loop");
endmodule // tdp_prog_properties

bind tdp_prog tdp_prog_properties tdp_prog_properties_i (.clk_sys, .sys_rst,
  .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp_err, .rsp_data, .bus_busy,
  .tgt_line_idx, .tgt_line, .tgt_page, .dec_active, .dec_cfg);

// File: tb/tdp_prog_tb_top.sv
/*
 * Self-checking bench of the programming block, driven at falling edges.
 * Assumes tdp_pkg, the design files and the checker are compiled first.
 */
`timescale 1ns/1ps
module tdp_prog_tb_top import tdp_pkg::*; ();
  logic clk_sys, sys_rst, cmd_valid, cmd_ready, rsp_valid, bus_busy;
  tdp_cmd_t cmd;
  logic [3:0] rsp_err;
  logic [31:0] rsp_data, r_data;
  logic [PTR_W-1:0] tgt_line_idx;
  tdp_attr_t tgt_line, el;
  logic [7:0] tgt_page;
  logic [NUM_DEC-1:0] dec_active;
  tdp_dec_cfg_t [NUM_DEC-1:0] dec_cfg;
  tdp_dec_cfg_t cfg_in;
  int fails, num_checks;

  tdp_prog tdp_prog_i (.clk_sys, .sys_rst, .cmd_valid, .cmd, .cmd_ready,
    .rsp_valid, .rsp_err, .rsp_data, .bus_busy, .tgt_line_idx, .tgt_line,
    .tgt_page, .dec_active, .dec_cfg);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Helpers
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_line(input tdp_attr_t got, input tdp_attr_t exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command: the field a is both decoder number and page.
  task automatic go(input tdp_op_t op, input logic [7:0] a,
    input logic [12:0] off, input logic [3:0] pr, input logic [31:0] v,
    input logic [3:0] e);
    int n;
    @(negedge clk_sys);
    cmd = '{op: op, dec_num: a[3:0], page: a, offset: off, prop: pr,
      value: v, dec_cfg: cfg_in};
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      n = n + 1;
      if (n > 40) begin
        fails++;
        conclude();
      end
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1) begin
      n = n + 1;
      if (n > 40) begin
        fails++;
        conclude();
      end
      @(negedge clk_sys);
    end
    r_data = rsp_data;
    chk_val({28'h0000000, rsp_err}, {28'h0000000, e});
  endtask

  // The line appears one cycle after the index is sampled.
  task automatic rd(input logic [12:0] idx, input tdp_attr_t exp);
    @(negedge clk_sys);
    tgt_line_idx = idx;
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk_line(tgt_line, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    @(negedge clk_sys);
    chk_val({24'h000000, tgt_page}, 32'h00000000);
    chk_val({24'h000000, dec_active}, 32'h00000000);
  endtask

  task automatic t_dec();
    go(OP_DEC_STAGE_WRITE, '0, '0, DP_SIZE, 32'h0000000C, ERR_NONE);
    go(OP_DEC_STAGE_WRITE, '0, '0, DP_BASE, 32'h00001000, ERR_NONE);
    go(OP_DEC_COMMIT, 8'h01, '0, '0, '0, ERR_NONE);
    chk_val({27'h0000000, dec_cfg[0].size}, 32'h0000000C);
    chk_val({24'h000000, dec_active}, 32'h00000001);
    go(OP_DEC_COMMIT, 8'h00, '0, '0, '0, ERR_DEC_NUM);
    go(OP_DEC_COMMIT, 8'h09, '0, '0, '0, ERR_DEC_NUM);
    go(OP_DEC_STAGE_WRITE, '0, '0, DP_SIZE, 32'h00000004, ERR_NONE);
    go(OP_DEC_COMMIT, 8'h01, '0, '0, '0, ERR_INCONSISTENT);
    go(OP_DEC_STAGED_QUERY, '0, '0, DP_SIZE, '0, ERR_NONE);
    chk_val(r_data, 32'h00000004);
    chk_val({27'h0000000, dec_cfg[0].size}, 32'h0000000C);
    go(OP_DEC_READBACK, 8'h01, '0, '0, '0, ERR_NONE);
    go(OP_DEC_STAGED_QUERY, '0, '0, DP_BASE, '0, ERR_NONE);
    chk_val(r_data, 32'h00001000);
    go(OP_DEC_STAGE_WRITE, '0, '0, DP_BASE, 32'h00000800, ERR_NONE);
    go(OP_DEC_COMMIT, 8'h01, '0, '0, '0, ERR_INCONSISTENT);
    go(OP_DEC_STAGE_WRITE, '0, '0, 4'h7, '0, ERR_PROP);
    go(tdp_op_t'(4'hF), '0, '0, '0, '0, ERR_OP);
    bus_busy = 1'b1;
    go(OP_DEC_COMMIT, 8'h01, '0, '0, '0, ERR_BUSY);
    go(OP_DEC_STAGED_QUERY, '0, '0, DP_SIZE, '0, ERR_BUSY);
    bus_busy = 1'b0;
    cfg_in = DEC_RESET;
    cfg_in.size = 5'h12;
    go(OP_DEC_SET_AND_COMMIT, 8'h08, '0, '0, '0, ERR_NONE);
    chk_val({24'h000000, dec_active}, 32'h00000081);
  endtask

  task automatic t_attr();
    go(OP_ATTR_PAGE_INIT, 8'h00, '0, '0, '0, ERR_PAGE);
    go(OP_ATTR_POINTER_PLACE, 8'h00, 13'h0003, '0, '0, ERR_PAGE);
    go(OP_ATTR_POINTER_PLACE, 8'hFF, 13'h0020, '0, '0, ERR_RANGE);
    // Only page 2 is filled, well under 256 lines in all.
    go(OP_ATTR_PAGE_INIT, 8'h02, '0, '0, '0, ERR_NONE);
    go(OP_ATTR_PAGE_SELECT, 8'h02, '0, '0, '0, ERR_NONE);
    chk_val({24'h000000, tgt_page}, 32'h00000002);
    for (int i = 0; i < 32; i++) begin
      rd(i[12:0], ATTR_INIT_LINE);
    end
    go(OP_ATTR_STAGE_WRITE, '0, '0, AP_WAITS, 32'h00000005, ERR_NONE);
    go(OP_ATTR_STAGE_WRITE, '0, '0, AP_TERM, 32'h00000002, ERR_NONE);
    rd(13'h0000, ATTR_INIT_LINE);
    go(OP_ATTR_LINE_WRITE, '0, '0, '0, '0, ERR_NONE);
    go(OP_ATTR_STAGE_WRITE, '0, '0, AP_WAITS, 32'h00000007, ERR_NONE);
    go(OP_ATTR_LINE_WRITE, '0, '0, '0, '0, ERR_NONE);
    el = ATTR_DEFAULT;
    el.term = 2'h2;
    el.waits = 5'h05;
    rd(13'h0000, el);
    el.waits = 5'h07;
    rd(13'h0001, el);
    rd(13'h0002, ATTR_INIT_LINE);
    go(OP_ATTR_STAGE_DEFAULTS, '0, '0, '0, '0, ERR_NONE);
    go(OP_ATTR_STAGE_QUERY, '0, '0, AP_TERM, '0, ERR_NONE);
    chk_val(r_data, 32'h00000000);
    rd(13'h0001, el);
    go(OP_ATTR_STAGE_WRITE, '0, '0, AP_WAITS, 32'h00000020, ERR_RANGE);
    go(OP_ATTR_STAGE_WRITE, '0, '0, 4'hF, 32'h00000001, ERR_PROP);
    // Page 1 plus 34 lines lands on line 2 of page 2.
    go(OP_ATTR_POINTER_PLACE, 8'h01, 13'h0022, '0, '0, ERR_NONE);
    go(OP_ATTR_STAGE_WRITE, '0, '0, AP_DSERR, 32'h00000001, ERR_NONE);
    go(OP_ATTR_LINE_WRITE, '0, '0, '0, '0, ERR_NONE);
    el = ATTR_DEFAULT;
    el.dserr = 1'b1;
    rd(13'h0002, el);
    go(OP_ATTR_POINTER_PLACE, 8'h02, 13'h0005, '0, '0, ERR_NONE);
    go(OP_DEC_COMMIT, 8'h08, '0, '0, '0, ERR_NONE);
    go(OP_ATTR_STAGE_WRITE, '0, '0, AP_WRPAR, 32'h00000001, ERR_NONE);
    go(OP_ATTR_LINE_WRITE, '0, '0, '0, '0, ERR_NONE);
    el.wrpar = 1'b1;
    rd(13'h0000, el);
    go(OP_ATTR_PAGE_INIT, 8'h02, '0, '0, '0, ERR_NONE);
    for (int i = 0; i < 3; i++) begin
      rd(i[12:0], ATTR_INIT_LINE);
    end
    go(OP_ATTR_PAGE_SELECT, 8'h00, '0, '0, '0, ERR_NONE);
    rd(13'h0005, ATTR_INIT_LINE);
  endtask

  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    bus_busy = 1'b0;
    tgt_line_idx = '0;
    cfg_in = DEC_RESET;
    fails = 0;
    num_checks = 0;
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
    t_dec();
    t_attr();
    conclude();
  end
endmodule // tdp_prog_tb_top
